// ===== hw/bb_rx_format_power_meter.sv
// What this block does
// - 48-bit gain-adjusted IQ is scaled, then rounded, then saturated.
// - two formats: single 16-bit IQ, or dual 8-bit IQ.
// - general format packs four 16-bit IQ samples per output word.
// - dual format packs eight 8-bit IQ samples per output word.
// - eight transmit and eight receive meter groups; each carrier maps to one.
// - carrier-to-group map is static; one signal type per group.
// - each group measures before or after the gain stage.
// - a group in off mode stays idle, updates nothing.
// - single mode: one trigger gives exactly one measurement and update.
// - continuous mode starts on a sync event, then counters repeat measurements.
// - after start, count the sync delay before accumulating I^2+Q^2.
// - accumulate over the integration period, counted in samples.
// - continuous mode restarts every interval, counted from delay end.
// - a separate power result is kept per carrier.
// - downlink sync arrives with transmit data and drives the sync bus.
// - uplink sync is a selected sync bus signal, delayed by a programmed count.
// - test generator replaces a carrier input with ramp, constant or LFSR.
// - one selected transmit or receive carrier is routed to the capture bus.
// - the number of active transmit channels is static.
module bb_rx_format_power_meter
    import bb_rx_pkg::*;
#(
    parameter int NUM_CARRIERS = 8,
    parameter int ACC_W = 48
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire logic I_RX_VALID,
    input wire wide_iq_t I_RX_SAMPLE,
    output logic O_RX_READY,
    input wire fmt_t I_FMT_MODE,
    input wire logic [SHIFT_W-1:0] I_FMT_SHIFT,
    output logic O_AIB_VALID,
    output logic [BUS_W-1:0] O_AIB_DATA,
    input wire logic I_AIB_READY,
    input wire logic I_TX_VALID,
    input wire carrier_sample_t I_TX_SAMPLE,
    input wire logic I_TX_DOWNLINK_SYNC,
    input wire logic [CAR_W:0] I_TX_NUM_CH,
    output logic O_TX_VALID,
    output carrier_sample_t O_TX_SAMPLE,
    input wire logic I_RXPM_VALID,
    input wire carrier_sample_t I_RXPM_SAMPLE,
    input wire logic [NUM_CARRIERS*CAR_W-1:0] I_TX_GROUP_MAP,
    input wire logic [NUM_CARRIERS*CAR_W-1:0] I_RX_GROUP_MAP,
    input wire logic [NUM_CARRIERS-1:0] I_TX_METER_EN,
    input wire logic [NUM_CARRIERS-1:0] I_RX_METER_EN,
    input wire meter_cfg_t I_METER_CFG [NUM_DIRS*GRP_PER_DIR],
    input wire logic [NUM_DIRS*GRP_PER_DIR-1:0] I_METER_TRIG,
    output logic [NUM_DIRS*GRP_PER_DIR-1:0] O_METER_DONE,
    output logic [ACC_W-1:0] O_POWER [NUM_DIRS][NUM_CARRIERS],
    input wire logic [SYNC_W-1:0] I_SYNC_BUS,
    output logic O_DOWNLINK_SYNC,
    input wire logic [SYNC_SEL_W-1:0] I_UPLINK_SYNC_SEL,
    input wire logic [CNT_W-1:0] I_UPLINK_SYNC_DELAY,
    output logic O_UPLINK_SYNC,
    input wire testgen_t I_TG_MODE,
    input wire logic [CAR_W-1:0] I_TG_CARRIER,
    input wire iq16_t I_TG_CONST,
    input wire logic [SAMP_W-1:0] I_TG_STEP,
    input wire logic I_CAP_DIR,
    input wire logic [CAR_W-1:0] I_CAP_CARRIER,
    output logic O_CAP_VALID,
    output iq16_t O_CAP_DATA
);
    localparam int NG = NUM_DIRS * GRP_PER_DIR;

    if (NUM_CARRIERS < 1 || NUM_CARRIERS > (1 << CAR_W) || ACC_W < PWR_W) begin : g_chk
        $error("carrier count or accumulator width out of range");
    end

    // ----------------------------------------
    // receive formatter
    // ----------------------------------------
    // scale round saturate
    function automatic logic [SAMP_W-1:0] scale_sat(input logic signed [IQ_W-1:0] x,
                                                   input logic [SHIFT_W-1:0] sh, input logic narrow);
        logic signed [IQ_W:0] r;
        logic signed [IQ_W:0] hi;
        logic signed [IQ_W:0] lo;
        r = (IQ_W+1)'(x);
        if (sh != 5'h00) begin
            r = r + ((IQ_W+1)'(1) <<< (sh - 5'h01));
        end
        r = r >>> sh;
        hi = narrow ? 25'sh000007F : 25'sh0007FFF;
        lo = narrow ? -25'sh0000080 : -25'sh0008000;
        if (r > hi) begin
            r = hi;
        end else if (r < lo) begin
            r = lo;
        end
        return r[SAMP_W-1:0];
    endfunction : scale_sat

    logic [2:0] slot;
    logic [BUS_W-1:0] pack;
    logic [BUS_W-1:0] buf_mem [BUF_DEPTH];
    logic buf_wr;
    logic buf_rd;
    logic [1:0] buf_cnt;
    logic last_slot;
    logic accept;
    logic push;
    logic pop;
    logic [SAMP_W-1:0] fi;
    logic [SAMP_W-1:0] fq;
    logic [BUS_W-1:0] next_pack;

    assign last_slot = (I_FMT_MODE == FMT_DUAL8) ? (slot == 3'h7) : (slot == 3'h3);
    // buffer full stalls the source only on the word-closing sample
    assign O_RX_READY = !last_slot || (buf_cnt != 2'h2);
    assign accept = I_RX_VALID && O_RX_READY;
    assign push = accept && last_slot;
    assign pop = O_AIB_VALID && I_AIB_READY;
    assign fi = scale_sat(I_RX_SAMPLE.i, I_FMT_SHIFT, I_FMT_MODE == FMT_DUAL8);
    assign fq = scale_sat(I_RX_SAMPLE.q, I_FMT_SHIFT, I_FMT_MODE == FMT_DUAL8);

    always_comb begin
        next_pack = pack;
        if (I_FMT_MODE == FMT_DUAL8) begin
            next_pack[DUAL_SLOT_W*slot +: DUAL_SLOT_W] = {fi[7:0], fq[7:0]};
        end else begin
            next_pack[GEN_SLOT_W*slot[1:0] +: GEN_SLOT_W] = {fi, fq};
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            slot <= SLOT_RST;
            pack <= '0;
        end else if (accept) begin
            slot <= last_slot ? SLOT_RST : slot + 3'h1;
            pack <= last_slot ? '0 : next_pack;
        end
    end

    // ----------------------------------------
    // two-entry output buffer
    // ----------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            buf_wr <= 1'b0;
            buf_rd <= 1'b0;
            buf_cnt <= 2'h0;
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
        end else begin
            if (push) begin
                buf_mem[buf_wr] <= next_pack;
                buf_wr <= !buf_wr;
            end
            if (pop) begin
                buf_rd <= !buf_rd;
            end
            buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
        end
    end

    assign O_AIB_VALID = (buf_cnt != 2'h0);
    assign O_AIB_DATA = buf_mem[buf_rd];

    // ----------------------------------------
    // transmit test generator and channel limit
    // ----------------------------------------
    logic [SAMP_W-1:0] ramp;
    logic [SAMP_W-1:0] lfsr;
    logic tg_hit;
    carrier_sample_t tx_s;
    iq16_t tg_val;
    logic tx_live;

    assign tx_live = I_TX_VALID && ({1'b0, I_TX_SAMPLE.carrier} < I_TX_NUM_CH);
    assign tg_hit = tx_live && (I_TG_MODE != TG_OFF) && (I_TX_SAMPLE.carrier == I_TG_CARRIER);

    always_comb begin
        tg_val = I_TG_CONST;
        case (I_TG_MODE)
            TG_RAMP: tg_val = '{i: ramp, q: ramp};
            TG_LFSR: tg_val = '{i: lfsr, q: ~lfsr};
            default: tg_val = I_TG_CONST;
        endcase
        tx_s = I_TX_SAMPLE;
        if (tg_hit) begin
            tx_s.pre = tg_val;
            tx_s.post = tg_val;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ramp <= '0;
            lfsr <= LFSR_SEED;
        end else if (tg_hit) begin
            ramp <= ramp + I_TG_STEP;
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_TX_VALID <= 1'b0;
            O_TX_SAMPLE <= '0;
        end else begin
            O_TX_VALID <= tx_live;
            O_TX_SAMPLE <= tx_s;
        end
    end

    // ----------------------------------------
    // power meter groups
    // ----------------------------------------
    logic [NUM_DIRS-1:0] pm_valid;
    carrier_sample_t pm_s [NUM_DIRS];
    logic [NUM_CARRIERS*CAR_W-1:0] gmap [NUM_DIRS];
    logic [NUM_CARRIERS-1:0] gen [NUM_DIRS];
    meter_state_t st [NG];
    logic [NG-1:0] grp_evt;

    assign pm_valid = {I_RXPM_VALID, tx_live};
    assign pm_s[0] = tx_s;
    assign pm_s[1] = I_RXPM_SAMPLE;
    assign gmap[0] = I_TX_GROUP_MAP;
    assign gmap[1] = I_RX_GROUP_MAP;
    assign gen[0] = I_TX_METER_EN;
    assign gen[1] = I_RX_METER_EN;

    for (genvar g = 0; g < NG; g++) begin : g_grp
        localparam int D = g / GRP_PER_DIR;
        localparam logic [CAR_W-1:0] GI = CAR_W'(g % GRP_PER_DIR);
        meter_cfg_t cfg;
        logic start;
        logic [CNT_W-1:0] dly_cnt;
        logic [CNT_W-1:0] int_cnt;
        logic [CNT_W-1:0] ivl_cnt;

        assign cfg = I_METER_CFG[g];
        assign grp_evt[g] = pm_valid[D] && gen[D][pm_s[D].carrier]
                            && (gmap[D][CAR_W*pm_s[D].carrier +: CAR_W] == GI);
        // trigger in single, sync event in continuous
        assign start = (cfg.mode == METER_SINGLE) ? I_METER_TRIG[g]
                     : (cfg.mode == METER_CONT) && I_SYNC_BUS[cfg.sync_sel];

        always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
            if (!I_RST_N) begin
                st[g] <= PM_IDLE;
                dly_cnt <= CNT_RST;
                int_cnt <= CNT_RST;
                ivl_cnt <= CNT_RST;
                O_METER_DONE[g] <= 1'b0;
            end else begin
                O_METER_DONE[g] <= 1'b0;
                case (st[g])
                    PM_IDLE: begin
                        dly_cnt <= CNT_RST;
                        int_cnt <= CNT_RST;
                        ivl_cnt <= CNT_RST;
                        if (start) begin
                            st[g] <= (cfg.delay == CNT_RST) ? PM_INTEG : PM_DELAY;
                        end
                    end
                    PM_DELAY: if (grp_evt[g]) begin
                        dly_cnt <= dly_cnt + 16'h0001;
                        if (dly_cnt == cfg.delay - 16'h0001) begin
                            st[g] <= PM_INTEG;
                        end
                    end
                    PM_INTEG: if (grp_evt[g]) begin
                        int_cnt <= int_cnt + 16'h0001;
                        ivl_cnt <= ivl_cnt + 16'h0001;
                        if (int_cnt + 16'h0001 >= cfg.integ) begin
                            O_METER_DONE[g] <= 1'b1;
                            st[g] <= (cfg.mode == METER_CONT) ? PM_WAIT : PM_IDLE;
                        end
                    end
                    PM_WAIT: if (grp_evt[g]) begin
                        ivl_cnt <= ivl_cnt + 16'h0001;
                        if (ivl_cnt + 16'h0001 >= cfg.interval) begin
                            ivl_cnt <= CNT_RST;
                            int_cnt <= CNT_RST;
                            st[g] <= PM_INTEG;
                        end
                    end
                    default: st[g] <= PM_IDLE;
                endcase
                if (cfg.mode == METER_OFF) begin
                    st[g] <= PM_IDLE;
                    O_METER_DONE[g] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // per-carrier accumulators and results
    // ----------------------------------------
    for (genvar d = 0; d < NUM_DIRS; d++) begin : g_dir
        for (genvar c = 0; c < NUM_CARRIERS; c++) begin : g_car
            localparam logic [CAR_W-1:0] CI = CAR_W'(c);
            logic [CAR_W-1:0] grp;
            int unsigned gsel;
            iq16_t sel;
            logic [PWR_W-1:0] pwr;
            logic hit;
            logic [ACC_W-1:0] acc;

            assign grp = gmap[d][CAR_W*c +: CAR_W];
            assign gsel = d * GRP_PER_DIR + int'(grp);
            assign sel = I_METER_CFG[gsel].post_gain ? pm_s[d].post : pm_s[d].pre;
            assign pwr = PWR_W'($signed(sel.i) * $signed(sel.i)) + PWR_W'($signed(sel.q) * $signed(sel.q));
            assign hit = pm_valid[d] && gen[d][c] && (pm_s[d].carrier == CI) && (st[gsel] == PM_INTEG);

            always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
                if (!I_RST_N) begin
                    acc <= '0;
                    O_POWER[d][c] <= '0;
                end else if (O_METER_DONE[gsel]) begin
                    // one result per carrier, latched only at period end
                    O_POWER[d][c] <= gen[d][c] ? acc : O_POWER[d][c];
                    acc <= hit ? ACC_W'(pwr) : '0;
                end else if (st[gsel] != PM_INTEG && st[gsel] != PM_WAIT) begin
                    acc <= '0;
                end else if (hit) begin
                    acc <= acc + ACC_W'(pwr);
                end
            end
        end
    end

    // ----------------------------------------
    // sync events
    // ----------------------------------------
    logic ul_busy;
    logic [CNT_W-1:0] ul_cnt;

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_DOWNLINK_SYNC <= 1'b0;
        end else begin
            // downlink sync taken with transmit data
            O_DOWNLINK_SYNC <= I_TX_VALID && I_TX_DOWNLINK_SYNC;
        end
    end

    // a new event while counting restarts the delay; only one is in flight
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ul_busy <= 1'b0;
            ul_cnt <= CNT_RST;
            O_UPLINK_SYNC <= 1'b0;
        end else begin
            O_UPLINK_SYNC <= 1'b0;
            if (I_SYNC_BUS[I_UPLINK_SYNC_SEL]) begin
                ul_busy <= 1'b1;
                ul_cnt <= I_UPLINK_SYNC_DELAY;
            end else if (ul_busy) begin
                if (ul_cnt == CNT_RST) begin
                    O_UPLINK_SYNC <= 1'b1;
                    ul_busy <= 1'b0;
                end else begin
                    ul_cnt <= ul_cnt - 16'h0001;
                end
            end
        end
    end

    // ----------------------------------------
    // capture test bus
    // ----------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_CAP_VALID <= 1'b0;
            O_CAP_DATA <= '0;
        end else begin
            O_CAP_VALID <= pm_valid[I_CAP_DIR] && (pm_s[I_CAP_DIR].carrier == I_CAP_CARRIER);
            O_CAP_DATA <= pm_s[I_CAP_DIR].post;
        end
    end
endmodule : bb_rx_format_power_meter

// ===== hw/bb_rx_pkg.sv
package bb_rx_pkg;
    localparam int IQ_W = 24;
    localparam int SAMP_W = 16;
    localparam int CAR_W = 3;
    localparam int GRP_PER_DIR = 8;
    localparam int NUM_DIRS = 2;
    localparam int CNT_W = 16;
    localparam int SHIFT_W = 5;
    localparam int SYNC_W = 8;
    localparam int SYNC_SEL_W = 3;
    localparam int BUS_W = 128;
    localparam int GEN_SLOTS = 4;
    localparam int DUAL_SLOTS = 8;
    localparam int GEN_SLOT_W = 32;
    localparam int DUAL_SLOT_W = 16;
    localparam int BUF_DEPTH = 2;
    localparam int PWR_W = 33;
    localparam logic [2:0] SLOT_RST = 3'h0;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

    typedef enum logic [1:0] {METER_OFF = 2'b00, METER_SINGLE = 2'b01, METER_CONT = 2'b11} meter_mode_t;
    // gray order along idle, delay, integrate, wait
    typedef enum logic [1:0] {PM_IDLE = 2'b00, PM_DELAY = 2'b01, PM_INTEG = 2'b11, PM_WAIT = 2'b10} meter_state_t;
    typedef enum logic [1:0] {TG_OFF = 2'b00, TG_RAMP = 2'b01, TG_CONST = 2'b10, TG_LFSR = 2'b11} testgen_t;
    typedef enum logic {FMT_GENERAL = 1'b0, FMT_DUAL8 = 1'b1} fmt_t;

    typedef struct packed {
        logic signed [IQ_W-1:0] i;
        logic signed [IQ_W-1:0] q;
    } wide_iq_t;

    typedef struct packed {
        logic signed [SAMP_W-1:0] i;
        logic signed [SAMP_W-1:0] q;
    } iq16_t;

    typedef struct packed {
        logic [CAR_W-1:0] carrier;
        iq16_t pre;
        iq16_t post;
    } carrier_sample_t;

    typedef struct packed {
        meter_mode_t mode;
        logic post_gain;
        logic [SYNC_SEL_W-1:0] sync_sel;
        logic [CNT_W-1:0] delay;
        logic [CNT_W-1:0] integ;
        logic [CNT_W-1:0] interval;
    } meter_cfg_t;
endpackage : bb_rx_pkg

// ===== tb/aib_peer_model.sv
module aib_peer_model
    import bb_rx_pkg::*;
(
    input wire logic clk,
    input wire logic stall,
    input wire logic i_valid,
    input wire logic [BUS_W-1:0] i_data,
    output logic o_ready,
    output logic o_tx_valid,
    output carrier_sample_t o_tx_sample,
    output logic o_downlink_sync
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [BUS_W-1:0] words [$];

    initial begin
        o_ready = 1'b0;
        o_tx_valid = 1'b0;
        o_tx_sample = '0;
        o_downlink_sync = 1'b0;
    end

    always @(negedge clk) begin
        o_ready <= !stall;
    end

    always @(posedge clk) begin
        if (i_valid && o_ready) begin
            words.push_back(i_data);
        end
    end

    task automatic send_tx(input carrier_sample_t s, input logic sync);
        @(negedge clk);
        o_tx_valid = 1'b1;
        o_tx_sample = s;
        o_downlink_sync = sync;
        @(negedge clk);
        o_tx_valid = 1'b0;
        o_tx_sample = ~s;
        o_downlink_sync = !sync;
    endtask : send_tx
endmodule : aib_peer_model

// ===== tb/bb_rx_format_power_meter_chk.sv
module bb_rx_format_power_meter_chk
    import bb_rx_pkg::*;
#(
    parameter int NUM_CARRIERS = 8,
    parameter int ACC_W = 48
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire logic I_RX_VALID,
    input wire logic O_RX_READY,
    input wire logic O_AIB_VALID,
    input wire logic [BUS_W-1:0] O_AIB_DATA,
    input wire logic I_AIB_READY,
    input wire logic I_TX_VALID,
    input wire logic I_TX_DOWNLINK_SYNC,
    input wire meter_cfg_t I_METER_CFG [NUM_DIRS*GRP_PER_DIR],
    input wire logic [NUM_DIRS*GRP_PER_DIR-1:0] O_METER_DONE,
    input wire logic [ACC_W-1:0] O_POWER [NUM_DIRS][NUM_CARRIERS],
    input wire logic [SYNC_W-1:0] I_SYNC_BUS,
    input wire logic O_DOWNLINK_SYNC,
    input wire logic [SYNC_SEL_W-1:0] I_UPLINK_SYNC_SEL,
    input wire logic [CNT_W-1:0] I_UPLINK_SYNC_DELAY,
    input wire logic O_UPLINK_SYNC
);
    // cycles since the selected sync event; saturates so a stale event never matches
    logic [17:0] since;

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RST_N);

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            since <= 18'h3FFFF;
        end else if (I_SYNC_BUS[I_UPLINK_SYNC_SEL]) begin
            since <= 18'h00001;
        end else if (since != 18'h3FFFF) begin
            since <= since + 18'h00001;
        end
    end

    AST_DL_FWD: assert property (O_DOWNLINK_SYNC == $past(I_TX_VALID && I_TX_DOWNLINK_SYNC))
        else $error("downlink sync not forwarded");
    AST_UL_WHEN: assert property (O_UPLINK_SYNC |-> since == {2'h0, I_UPLINK_SYNC_DELAY} + 18'h00002)
        else $error("uplink sync at wrong time");
    AST_UL_DUE: assert property (since == {2'h0, I_UPLINK_SYNC_DELAY} + 18'h00002 |-> O_UPLINK_SYNC)
        else $error("uplink sync missing");
    AST_AIB_HOLD: assert property (O_AIB_VALID && !I_AIB_READY |=> O_AIB_VALID && $stable(O_AIB_DATA))
        else $error("output word changed while stalled");
    AST_RDY_FULL: assert property (!O_RX_READY |-> O_AIB_VALID)
        else $error("input refused with empty buffer");
    AST_WORD_CAUSE: assert property ($rose(O_AIB_VALID) |-> $past(I_RX_VALID && O_RX_READY))
        else $error("word appeared without a taken sample");
    AST_OFF_IDLE: assert property ($past(I_METER_CFG[8].mode, 2) == METER_OFF && $past(I_METER_CFG[8].mode)
        == METER_OFF && I_METER_CFG[8].mode == METER_OFF |-> !O_METER_DONE[8])
        else $error("meter in off mode finished a measurement");
    AST_PWR_HOLD: assert property (!$past(|O_METER_DONE[15:8]) |-> $stable(O_POWER[1][0]))
        else $error("power result changed without a completed period");
    AST_SINGLE_ONCE: assert property (I_METER_CFG[8].mode == METER_SINGLE && O_METER_DONE[8]
        |=> !O_METER_DONE[8] [*3])
        else $error("single mode finished twice");
endmodule : bb_rx_format_power_meter_chk

bind bb_rx_format_power_meter bb_rx_format_power_meter_chk #(.NUM_CARRIERS(NUM_CARRIERS), .ACC_W(ACC_W)) i_chk (.*);

// ===== tb/bb_rx_format_power_meter_tb_top.sv
module bb_rx_format_power_meter_tb_top import bb_rx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, rx_v = 1'b0, pm_v = 1'b0, stall = 1'b1;
    logic rx_rdy, aib_v, aib_r, tx_v, dl, otx_v, dls, uls, capv;
    wide_iq_t rx_s = '0;
    fmt_t fmt = FMT_GENERAL;
    logic [SHIFT_W-1:0] sh = '0;
    logic [BUS_W-1:0] aib_d;
    carrier_sample_t tx_s, otx_s, pm_s = '0;
    meter_cfg_t cfg [16];
    logic [15:0] trig = '0, done, uldly = 16'h0003;
    logic [47:0] pwr [2][8];
    logic [7:0] sbus = '0;
    logic [3:0] num_ch = 4'h7;
    logic [2:0] ulsel = 3'h2, tgc = 3'h0, capcar = 3'h0;
    logic capdir = 1'b0;
    testgen_t tgm = TG_OFF;
    iq16_t tgk = 32'h1234ABCD, capdat;
    int err_count = 0, cmp_count = 0, cyc = 0;
    int dcnt [16];

    bb_rx_format_power_meter i_dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_RX_VALID(rx_v), .I_RX_SAMPLE(rx_s),
        .O_RX_READY(rx_rdy), .I_FMT_MODE(fmt), .I_FMT_SHIFT(sh), .O_AIB_VALID(aib_v), .O_AIB_DATA(aib_d),
        .I_AIB_READY(aib_r), .I_TX_VALID(tx_v), .I_TX_SAMPLE(tx_s), .I_TX_DOWNLINK_SYNC(dl), .I_TX_NUM_CH(num_ch),
        .O_TX_VALID(otx_v), .O_TX_SAMPLE(otx_s), .I_RXPM_VALID(pm_v), .I_RXPM_SAMPLE(pm_s),
        .I_TX_GROUP_MAP(24'hFAC688), .I_RX_GROUP_MAP(24'hFAC688), .I_TX_METER_EN(8'h01), .I_RX_METER_EN(8'h03),
        .I_METER_CFG(cfg), .I_METER_TRIG(trig), .O_METER_DONE(done), .O_POWER(pwr), .I_SYNC_BUS(sbus),
        .O_DOWNLINK_SYNC(dls), .I_UPLINK_SYNC_SEL(ulsel), .I_UPLINK_SYNC_DELAY(uldly), .O_UPLINK_SYNC(uls),
        .I_TG_MODE(tgm), .I_TG_CARRIER(tgc), .I_TG_CONST(tgk), .I_TG_STEP(16'h0001), .I_CAP_DIR(capdir),
        .I_CAP_CARRIER(capcar), .O_CAP_VALID(capv), .O_CAP_DATA(capdat));
    aib_peer_model i_peer (.clk(clk), .stall(stall), .i_valid(aib_v), .i_data(aib_d), .o_ready(aib_r),
        .o_tx_valid(tx_v), .o_tx_sample(tx_s), .o_downlink_sync(dl));

    always #2 clk = ~clk;

    always @(posedge clk) begin
        cyc++;
        foreach (dcnt[j]) dcnt[j] += int'(done[j] === 1'b1);
        if (cyc == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic check(input string nm, input logic [127:0] got, input logic [127:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // expected output code: round, shift, clamp to width
    function automatic logic [15:0] fmt_exp(input logic signed [23:0] v, input int s, input int w);
        longint x;
        longint mx;
        x = v;
        x = (x + (64'sh1 <<< (s - 1))) >>> s;
        mx = (64'sh1 <<< (w - 1)) - 1;
        if (x > mx) x = mx;
        if (x < -mx - 1) x = -mx - 1;
        return 16'(x) & 16'((1 << w) - 1);
    endfunction : fmt_exp

    task automatic send_rx(input wide_iq_t s);
        @(negedge clk);
        rx_v = 1'b1;
        rx_s = s;
        do @(posedge clk); while (rx_rdy !== 1'b1);
        @(negedge clk);
        rx_v = 1'b0;
        rx_s = ~s;
    endtask : send_rx

    // three words into a stalled receiver: the third must be refused, none lost
    task automatic t_fmt(input fmt_t m, input int s);
        int n;
        wide_iq_t v [8];
        logic [127:0] e;
        fmt = m;
        sh = SHIFT_W'(s);
        stall = 1'b1;
        i_peer.words.delete();
        n = (m == FMT_GENERAL) ? 4 : 8;
        for (int k = 0; k < n; k++) begin
            v[k].i = 24'(k * 'h234567 - 'h400000);
            v[k].q = 24'(k * 'h1357 - 'h80);
            if (m == FMT_GENERAL) e[32*k+:32] = {fmt_exp(v[k].i, s, 16), fmt_exp(v[k].q, s, 16)};
            else e[16*k+:16] = {8'(fmt_exp(v[k].i, s, 8)), 8'(fmt_exp(v[k].q, s, 8))};
        end
        fork
            repeat (3) for (int k = 0; k < n; k++) send_rx(v[k]);
            begin
                repeat (60) @(negedge clk);
                check("rx_ready_full", rx_rdy, 1'b0);
                stall = 1'b0;
            end
        join
        repeat (10) @(negedge clk);
        check("word_count", i_peer.words.size(), 3);
        foreach (i_peer.words[j]) check("aib_word", i_peer.words[j], e);
    endtask : t_fmt

    task automatic t_single();
        // post gain on group 8, pre gain on group 9 to tell them apart
        cfg[8] = '{METER_SINGLE, 1'b1, 3'h0, 16'h0002, 16'h0003, 16'h0000};
        cfg[9] = '{METER_SINGLE, 1'b0, 3'h0, 16'h0000, 16'h0002, 16'h0000};
        foreach (dcnt[j]) dcnt[j] = 0;
        @(negedge clk);
        trig = 16'h0300;
        @(negedge clk);
        trig = '0;
        for (int k = 0; k < 16; k++) begin
            pm_v = 1'b1;
            pm_s.carrier = CAR_W'(k % 2);
            if (k % 2 == 0) pm_s.post = (k < 4 || k >= 10) ? 32'h000A0000 : 32'h00030004;
            else pm_s.pre = (k < 4) ? 32'h00050000 : 32'h00010001;
            @(negedge clk);
        end
        pm_v = 1'b0;
        repeat (4) @(negedge clk);
        check("power_post", pwr[1][0], 48'h4B);
        check("power_pre", pwr[1][1], 48'h32);
        check("single_done", dcnt[8], 1);
        check("single_done_pre", dcnt[9], 1);
    endtask : t_single

    task automatic t_cont();
        cfg[0] = '{METER_CONT, 1'b1, 3'h1, 16'h0001, 16'h0002, 16'h0004};
        foreach (dcnt[j]) dcnt[j] = 0;
        @(negedge clk);
        sbus = 8'h02;
        @(negedge clk);
        sbus = '0;
        repeat (12) i_peer.send_tx('{3'h0, 32'h0, 32'h00020000}, 1'b0);
        repeat (4) @(negedge clk);
        check("cont_power", pwr[0][0], 48'h8);
        check("cont_done", dcnt[0], 3);
        check("tx_other_group", dcnt[1], 0);
    endtask : t_cont

    task automatic t_sync();
        int n;
        fork
            i_peer.send_tx('{3'h7, 32'h0, 32'h0}, 1'b1);
            begin
                repeat (2) @(negedge clk);
                check("downlink_sync", dls, 1'b1);
                check("tx_dropped", otx_v, 1'b0);
            end
        join
        sbus = 8'h04;
        n = 0;
        do begin
            @(negedge clk);
            sbus = '0;
            n++;
        end while (uls !== 1'b1 && n < 50);
        check("ul_delay", n, uldly + 2);
    endtask : t_sync

    task automatic t_tgen();
        for (int m = 0; m < 4; m++) begin
            tgm = testgen_t'(m);
            capcar = CAR_W'(m);
            fork
                i_peer.send_tx('{3'h0, 32'h0, 32'h11112222}, 1'b0);
                begin
                    repeat (2) @(negedge clk);
                    check("tg_valid", otx_v, 1'b1);
                    check("cap_valid", capv, m == 0);
                    case (tgm)
                        TG_OFF: check("tg_off", otx_s.post, 32'h11112222);
                        TG_CONST: check("tg_const", otx_s.post, tgk);
                        TG_RAMP: check("tg_ramp", otx_s.post, 32'h00000000);
                        default: check("tg_lfsr", otx_s.post.q, 16'(~otx_s.post.i));
                    endcase
                    if (tgm == TG_OFF) check("cap_data", capdat, 32'h11112222);
                end
            join
        end
        tgm = TG_OFF;
    endtask : t_tgen

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    initial begin
        foreach (cfg[j]) cfg[j] = '0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        t_fmt(FMT_GENERAL, 4);
        t_fmt(FMT_DUAL8, 8);
        t_single();
        t_cont();
        t_sync();
        t_tgen();
        print_verdict();
    end
endmodule : bb_rx_format_power_meter_tb_top
